// ---- common/e1_port_pkg.sv ----
/*
 * Shared constants for the E1 line-side data port: register map, reset values,
 * format, loss-of-signal and clock-fallback counts, and the line symbol type.
 * Assumes a 100 MHz system clock; every figure below is in those cycles or in bits.
 */
package e1_port_pkg;

    // register byte addresses, one aligned word each
    localparam logic [7:0] ADDR_STATUS = 8'h00;
    localparam logic [7:0] ADDR_MASK = 8'h04;
    localparam logic [7:0] ADDR_STATE = 8'h08;

    // status bit positions
    localparam int ST_LOS_SET = 0;
    localparam int ST_LOS_CLR = 1;
    localparam int ST_VIOL = 2;
    localparam int ST_FMT = 3;
    localparam int ST_W = 4;

    // state register fields
    localparam int SR_SINGLE = 0;
    localparam int SR_LOS = 1;
    localparam int SR_HOST = 2;
    localparam int SR_HDB3 = 3;
    localparam int SR_MREF = 4;
    localparam int SR_HALF_LSB = 8;

    localparam logic [ST_W-1:0] STATUS_RST = 4'h0;
    localparam logic [ST_W-1:0] MASK_RST = 4'h0;

    // transmit format select: unbroken highs needed for single-rail
    localparam logic [4:0] FMT_RUN = 5'h10;

    // loss of signal, in received bits
    localparam logic [7:0] LOS_ZEROS = 8'hAF;
    localparam logic [7:0] LOS_WINDOW = 8'hAF;
    localparam logic [7:0] LOS_MIN_ONES = 8'h16;
    localparam logic [6:0] LOS_MAX_ZRUN = 7'h64;

    // mode pin classification window and edges that mean "tied to the clock"
    localparam logic [8:0] MODE_WIN = 9'h100;
    localparam logic [8:0] MODE_MIN_EDGES = 9'h004;

    // master reference counts as absent after this many cycles without a rising edge
    localparam logic [8:0] MREF_TIMEOUT = 9'h100;

    // line symbols in the transmit substitution pipeline
    typedef enum logic [1:0] {
        SYM_ZERO = 2'h0,
        SYM_ONE = 2'h1,
        SYM_BPULSE = 2'h2,
        SYM_VIOL = 2'h3
    } sym_t;

endpackage

// ---- dv/e1_framer_model.sv ----
/* Far-end framer and line model: free-running 125 ns transmit and receive bit clocks,
   transmit rails and sliced receive line pulses. Assumes the bench sets data by level. */
`timescale 1ns/1ps
module e1_framer_model (
    // data to send: rails, and line pattern 0 zeros, 1 alternate, 2 plus only, 3 minus only
    input wire logic plus_i,
    input wire logic minus_i,
    input wire logic [1:0] pat_i,
    // transmit side
    output logic tx_line_clock_o,
    output logic tx_plus_rail_o,
    output logic tx_minus_rail_o,
    // receive line
    output logic rx_bit_clock_o,
    output logic rx_line_positive_o,
    output logic rx_line_negative_o
);
    logic pol_q;
    initial begin
        tx_line_clock_o = 1'b1;
        rx_bit_clock_o = 1'b0;
        {tx_plus_rail_o, tx_minus_rail_o, rx_line_positive_o, rx_line_negative_o} = 4'h0;
        pol_q = 1'b0;
        // receive clock offset so it never shares an edge with the system clock
        #21;
        forever #62.5 rx_bit_clock_o = ~rx_bit_clock_o;
    end
    always #62.5 tx_line_clock_o = ~tx_line_clock_o;
    // rails move half a bit away from the sampling fall, so they are steady around it
    always @(posedge tx_line_clock_o) begin
        tx_plus_rail_o <= plus_i;
        tx_minus_rail_o <= minus_i;
    end
    always @(negedge rx_bit_clock_o) begin
        pol_q <= ~pol_q;
        rx_line_positive_o <= (pat_i == 2'h1) ? pol_q : (pat_i == 2'h2);
        rx_line_negative_o <= (pat_i == 2'h1) ? ~pol_q : (pat_i == 2'h3);
    end
endmodule // e1_framer_model

// ---- dv/e1_port_properties.sv ----
/* Port checker for the E1 data port: bus answer, transmit timing, receive alignment,
   loss and clock recovery. Assumes it is bound to the top module and sees its ports only. */
`timescale 1ns/1ps
module e1_port_properties #(
    parameter int HALF_W = 8
) (
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire logic tx_line_clock_i,
    input wire logic rx_line_positive_i,
    input wire logic rx_line_negative_i,
    input wire logic mode_i,
    input wire logic hsel_i,
    input wire logic [7:0] haddr_i,
    input wire logic [1:0] htrans_i,
    input wire logic hwrite_i,
    input wire logic hready_i,
    input wire logic tx_line_positive_o,
    input wire logic tx_line_negative_o,
    input wire logic rx_plus_rail_o,
    input wire logic rx_clock_o,
    input wire logic signal_loss_indicator_o,
    input wire logic [31:0] hrdata_o,
    input wire logic hreadyout_o,
    input wire logic hresp_o
);
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!rst_n_i);
    sequence s_read_req;
        hsel_i && hready_i && htrans_i[1] && !hwrite_i;
    endsequence
    sequence s_unmapped_read;
        s_read_req ##0 (haddr_i > 8'h08);
    endsequence
    bus_ready_a: assert property (hreadyout_o && !hresp_o)
        else $error("bus not ready or error response");
    unmapped_read_a: assert property (s_unmapped_read |=> hrdata_o == 32'h0)
        else $error("unmapped read returned data");
    rdata_idle_a: assert property (!(hsel_i && hready_i && htrans_i[1] && !hwrite_i)
        |=> hrdata_o == 32'h0) else $error("read data outside a read");
    tx_exclusive_a: assert property (!(tx_line_positive_o && tx_line_negative_o))
        else $error("both line polarities driven");
    tx_timing_a: assert property ($changed({tx_line_positive_o, tx_line_negative_o})
        |-> !$past(tx_line_clock_i, 2)) else $error("line moved away from clock fall");
    los_zero_a: assert property ($rose(signal_loss_indicator_o)
        |-> !$past(rx_line_positive_i, 5) && !$past(rx_line_negative_i, 5))
        else $error("loss raised on a mark");
    edge_pin_a: assert property (!mode_i && $changed(rx_plus_rail_o)
        |-> !rx_clock_o && $past(rx_clock_o, 2)) else $error("data moved off fall");
    rclk_run_a: assert property (rst_n_i |-> ##[1:40] $changed(rx_clock_o))
        else $error("recovered clock stopped");
    read_seen_c: cover property (s_unmapped_read);
endmodule // e1_port_properties

bind e1_port e1_port_properties #(.HALF_W(HALF_W)) u_props (.clk_i, .rst_n_i,
    .tx_line_clock_i, .rx_line_positive_i, .rx_line_negative_i, .mode_i, .hsel_i, .haddr_i,
    .htrans_i, .hwrite_i, .hready_i, .tx_line_positive_o, .tx_line_negative_o,
    .rx_plus_rail_o, .rx_clock_o, .signal_loss_indicator_o, .hrdata_o, .hreadyout_o,
    .hresp_o);

// ---- dv/test_e1_port.sv ----
/* Self-checking bench for the E1 data port: bus reads and writes, transmit format,
   receive rails, violation flag, interrupt and loss. Assumes the framer model alongside. */
`timescale 1ns/1ps
module test_e1_port;
    import e1_port_pkg::*;
    logic clk_i = 1'b0;
    logic rst_n_i = 1'b0;
    logic mclk = 1'b0;
    logic plus = 1'b0;
    logic minus = 1'b0;
    logic [1:0] pat = 2'h1;
    logic hsel_i = 1'b0;
    logic [7:0] haddr_i = 8'h00;
    logic [1:0] htrans_i = 2'h0;
    logic hwrite_i = 1'b0;
    logic [31:0] hwdata_i = 32'h0;
    logic [31:0] rd;
    wire logic tx_clk, tx_p, tx_m, rx_clk, rx_p, rx_n;
    wire logic txo_p, txo_n, rx_plus, rx_minus, rclk, signal_loss_indicator, hready, hresp, irq;
    wire logic [31:0] hrdata;
    // mode pin strapped to the recovered clock when tie is set
    logic tie = 1'b0;
    wire logic mode_pin;
    assign mode_pin = tie & rclk;
    int failures = 0;
    int checks = 0;
    always #5 clk_i = ~clk_i;
    always #244 mclk = ~mclk;

    e1_framer_model far (.plus_i(plus), .minus_i(minus), .pat_i(pat), .tx_line_clock_o(tx_clk),
        .tx_plus_rail_o(tx_p), .tx_minus_rail_o(tx_m), .rx_bit_clock_o(rx_clk),
        .rx_line_positive_o(rx_p), .rx_line_negative_o(rx_n));
    e1_port DUT (.clk_i, .rst_n_i, .tx_line_clock_i(tx_clk), .tx_plus_rail_i(tx_p),
        .tx_minus_rail_i(tx_m), .rx_line_positive_i(rx_p), .rx_line_negative_i(rx_n),
        .rx_bit_clock_i(rx_clk), .mode_i(mode_pin), .output_edge_select_i(1'b0),
        .master_clock_i(mclk), .tx_line_positive_o(txo_p), .tx_line_negative_o(txo_n),
        .rx_plus_rail_o(rx_plus), .rx_minus_rail_o(rx_minus), .rx_clock_o(rclk),
        .signal_loss_indicator_o(signal_loss_indicator), .hsel_i, .haddr_i, .htrans_i, .hwrite_i,
        .hsize_i(3'h2), .hwdata_i, .hready_i(hready), .hrdata_o(hrdata),
        .hreadyout_o(hready), .hresp_o(hresp), .irq_o(irq));

    task automatic close_out();
        $display("checks %0d failures %0d", checks, failures);
        if (failures == 0 && checks > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp) begin
            failures++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    // ready is taken as sampled at the edge, so the wait sees pre-edge values
    task automatic wait_ready();
        int n;
        n = 0;
        do begin
            @(posedge clk_i);
            n++;
        end while (hready !== 1'b1 && n < 50);
        if (hready !== 1'b1) begin
            failures++;
            $display("mismatch at %0t: bus never ready", $time);
            close_out();
        end
    endtask
    task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] wd);
        @(posedge clk_i);
        hsel_i <= 1'b1;
        htrans_i <= 2'h2;
        haddr_i <= a;
        hwrite_i <= wr;
        wait_ready();
        hsel_i <= 1'b0;
        htrans_i <= 2'h0;
        hwdata_i <= wd;
        wait_ready();
        rd = hrdata;
    endtask
    task automatic rdm(input logic [7:0] a, input logic [31:0] m, input logic [31:0] exp);
        bus(1'b0, a, 32'h0);
        chk(rd & m, exp);
    endtask
    task automatic txb(input int n);
        repeat (n) @(negedge tx_clk);
    endtask
    task automatic rxb(input int n);
        repeat (n) @(posedge rx_clk);
    endtask
    task automatic set_tx(input logic p, input logic m);
        @(posedge clk_i);
        plus <= p;
        minus <= m;
    endtask
    task automatic set_pat(input logic [1:0] v);
        @(posedge clk_i);
        pat <= v;
    endtask

    initial begin
        repeat (3) @(posedge clk_i);
        rst_n_i <= 1'b1;
        rdm(ADDR_STATUS, 32'hFFFF_FFFF, 32'h0);
        rdm(ADDR_MASK, 32'hFFFF_FFFF, 32'h0);
        bus(1'b1, 8'h10, 32'hFFFF_FFFF);
        rdm(8'h10, 32'hFFFF_FFFF, 32'h0);
        set_pat(2'h2);
        rxb(10);
        chk(32'({rx_plus, rx_minus}), 32'h2);
        set_pat(2'h3);
        rxb(10);
        chk(32'({rx_plus, rx_minus}), 32'h1);
        set_tx(1'b1, 1'b0);
        txb(3);
        chk(32'({txo_p, txo_n}), 32'h2);
        set_tx(1'b0, 1'b1);
        txb(10);
        chk(32'({txo_p, txo_n}), 32'h1);
        // two low samples must restart the run
        set_tx(1'b0, 1'b0);
        txb(2);
        set_tx(1'b0, 1'b1);
        txb(10);
        rdm(ADDR_STATE, 32'h1, 32'h0);
        txb(8);
        rdm(ADDR_STATE, 32'h1F, 32'h11);
        @(posedge clk_i);
        tie <= 1'b1;
        repeat (600) @(posedge clk_i);
        rdm(ADDR_STATE, 32'h1F, 32'h19);
        set_pat(2'h2);
        rxb(10);
        chk(32'({rx_plus, rx_minus}), 32'h3);
        rdm(ADDR_STATUS, 32'hC, 32'hC);
        bus(1'b1, ADDR_MASK, 32'h8);
        repeat (2) @(posedge clk_i);
        chk(32'(irq), 32'h1);
        bus(1'b1, ADDR_STATUS, 32'h8);
        repeat (2) @(posedge clk_i);
        chk(32'(irq), 32'h0);
        set_tx(1'b0, 1'b0);
        txb(2);
        rdm(ADDR_STATE, 32'h1F, 32'h10);
        chk(32'(irq), 32'h1);
        bus(1'b1, ADDR_STATUS, 32'hF);
        bus(1'b1, ADDR_MASK, 32'h0);
        set_pat(2'h0);
        rxb(165);
        chk(32'(signal_loss_indicator), 32'h0);
        rxb(20);
        chk(32'(signal_loss_indicator), 32'h1);
        set_pat(2'h1);
        rxb(195);
        chk(32'(signal_loss_indicator), 32'h0);
        rdm(ADDR_STATUS, 32'h3, 32'h3);
        close_out();
    end
endmodule // test_e1_port

// ---- hw/e1_port.sv ----
/*
 * E1 line-side data port: transmit rail/format handling with substitution coder,
 * receive rail outputs, violation flag, loss of signal, recovered-clock fallback,
 * AHB-Lite status/mask registers and a level interrupt.
 * Assumes the line and control pins are asynchronous and sampled at 100 MHz; the receive line pulses
 * arrive as sliced logic levels together with a bit clock from the analog recovery.
 */
// The address map and the AHB-Lite interface to the registers are this design's own decisions.
// How it works
// - Transmit rails are sampled on each falling edge of the transmit clock.
// - In two-rail mode a plus-rail one gives a positive pulse, a minus-rail one a negative.
// - Sixteen unbroken high samples of the select pin switch to single-rail from the plus pin.
// - A low sample of the select pin returns transmit to two-rail input.
// - In single-rail mode the plus receive pin carries NRZ data, the minus pin the violation flag.
// - Under pin control received data is valid at the recovered clock's rising edge.
// - Under host control the edge-select pin picks the valid recovered clock edge.
// - In two-rail mode a positive line pulse drives the plus receive output, a negative one the minus output.
// - The violation flag stands in the same bit period as the offending NRZ bit.
// - With the coder active, violations of valid zero substitutions are not flagged.
// - The recovered clock falls back to the master reference, or holds its rate, in loss.
// - Under host control, edge-select high makes data valid on the falling edge, low on the rising edge.
// - The mode pin toggling at the recovered clock means pin control plus coder in single-rail.
// - Loss after 175 zeros; cleared by 12.5% ones in a 175-bit window with runs under 100.
`timescale 1ns/1ps
module e1_port
    import e1_port_pkg::*;
#(
    parameter int HALF_W = 8
) (
    // clock and reset
    input wire logic clk_i,
    input wire logic rst_n_i,
    // transmit side from the framer
    input wire logic tx_line_clock_i,
    input wire logic tx_plus_rail_i,
    input wire logic tx_minus_rail_i,
    // receive line, sliced, with its bit clock
    input wire logic rx_line_positive_i,
    input wire logic rx_line_negative_i,
    input wire logic rx_bit_clock_i,
    // control pins
    input wire logic mode_i,
    input wire logic output_edge_select_i,
    input wire logic master_clock_i,
    // line driver
    output logic tx_line_positive_o,
    output logic tx_line_negative_o,
    // receive side to the framer
    output logic rx_plus_rail_o,
    output logic rx_minus_rail_o,
    output logic rx_clock_o,
    output logic signal_loss_indicator_o,
    // AHB-Lite slave
    input wire logic hsel_i,
    input wire logic [7:0] haddr_i,
    input wire logic [1:0] htrans_i,
    input wire logic hwrite_i,
    input wire logic [2:0] hsize_i,
    input wire logic [31:0] hwdata_i,
    input wire logic hready_i,
    output logic [31:0] hrdata_o,
    output logic hreadyout_o,
    output logic hresp_o,
    // interrupt
    output logic irq_o
);
    initial begin
        if (HALF_W < 6 || HALF_W > 16) $error("e1_port: HALF_W must be 6..16");
    end

    logic [8:0] lvl, rise, fall;
    pin_sync #(.WIDTH(9)) u_sync (
        .clk_i(clk_i),
        .rst_n_i(rst_n_i),
        .pin_i({master_clock_i, output_edge_select_i, mode_i, rx_line_negative_i,
                rx_line_positive_i, rx_bit_clock_i, tx_minus_rail_i, tx_plus_rail_i,
                tx_line_clock_i}),
        .level_o(lvl),
        .rise_o(rise),
        .fall_o(fall)
    );

    // mode pin: steady high = host, toggling = pin control with coder
    logic [8:0] mwin_q, mwin_d, medge_q, medge_d;
    logic host_q, host_d, mtog_q, mtog_d;
    always_comb begin
        mwin_d = mwin_q + 9'h001;
        medge_d = medge_q + {8'h00, rise[6] | fall[6]};
        host_d = host_q;
        mtog_d = mtog_q;
        if (mwin_q == MODE_WIN - 9'h001) begin
            mwin_d = '0;
            medge_d = '0;
            mtog_d = (medge_q >= MODE_MIN_EDGES);
            host_d = lvl[6] && (medge_q < MODE_MIN_EDGES);
        end
    end

    // transmit: format run counter, coder pipeline, line pulses
    logic [4:0] fmt_q, fmt_d;
    logic single_q, single_d, hdb3;
    sym_t [3:0] esr_q, esr_d;
    logic lastpol_q, lastpol_d, par_q, par_d, txp_q, txp_d, txn_q, txn_d;
    sym_t out_sym;
    logic par_n, pol_n;
    assign hdb3 = mtog_q && single_q;
    always_comb begin
        fmt_d = fmt_q;
        single_d = single_q;
        esr_d = esr_q;
        lastpol_d = lastpol_q;
        par_d = par_q;
        txp_d = txp_q;
        txn_d = txn_q;
        out_sym = esr_q[3];
        par_n = par_q;
        pol_n = lastpol_q;
        if (fall[0]) begin
            if (lvl[2]) begin
                if (fmt_q != FMT_RUN) fmt_d = fmt_q + 5'h01;
                if (fmt_q + 5'h01 >= FMT_RUN) single_d = 1'b1;
            end else begin
                fmt_d = '0;
                single_d = 1'b0;
            end
            if (single_q) begin
                unique case (out_sym)
                    SYM_ZERO: ;
                    SYM_ONE, SYM_BPULSE: begin
                        pol_n = ~lastpol_q;
                        par_n = ~par_q;
                    end
                    SYM_VIOL: par_n = 1'b0;
                endcase
                txp_d = (out_sym != SYM_ZERO) && pol_n;
                txn_d = (out_sym != SYM_ZERO) && !pol_n;
                lastpol_d = pol_n;
                par_d = par_n;
                esr_d[3:1] = esr_q[2:0];
                esr_d[0] = lvl[1] ? SYM_ONE : SYM_ZERO;
                if (hdb3 && esr_d == {4{SYM_ZERO}}) begin
                    // odd pulses since the last violation: 000V, even: B00V
                    esr_d[0] = SYM_VIOL;
                    if (!par_n) esr_d[3] = SYM_BPULSE;
                end
            end else begin
                txp_d = lvl[1];
                txn_d = lvl[2];
                esr_d = '{default: SYM_ZERO};
            end
        end
    end

    // receive: violation detection, substitution removal, loss of signal
    logic [2:0] hist_q [4], hist_d [4]; // {positive, negative, violation}
    logic rlast_q, rlast_d, rseen_q, rseen_d;
    logic [2:0] bit_q, bit_d;
    logic [7:0] zrun_q, zrun_d, wcnt_q, wcnt_d, wones_q, wones_d;
    logic [6:0] wzrun_q, wzrun_d;
    logic los_q, los_d, wact_q, wact_d, viol_ev;
    logic pulse, viol, sub;
    always_comb begin
        hist_d = hist_q;
        rlast_d = rlast_q;
        rseen_d = rseen_q;
        bit_d = bit_q;
        zrun_d = zrun_q;
        wcnt_d = wcnt_q;
        wones_d = wones_q;
        wzrun_d = wzrun_q;
        los_d = los_q;
        wact_d = wact_q;
        pulse = lvl[4] | lvl[5];
        viol = pulse && rseen_q && (lvl[4] == rlast_q);
        sub = viol && hist_q[0][2:1] == 2'b00 && hist_q[1][2:1] == 2'b00 &&
              (hist_q[2][2:1] == 2'b00 || hist_q[2][2] == lvl[4]);
        if (rise[3]) begin
            bit_d = hist_q[3];
            hist_d[3] = hist_q[2];
            hist_d[2] = hist_q[1];
            hist_d[1] = hist_q[0];
            hist_d[0] = {lvl[4], lvl[5], viol};
            if (hdb3 && sub) begin
                hist_d[0] = 3'b000;
                hist_d[3] = 3'b000;
            end
            if (pulse) begin
                rlast_d = lvl[4];
                rseen_d = 1'b1;
            end
            zrun_d = pulse ? 8'h00 : (zrun_q == LOS_ZEROS ? zrun_q : zrun_q + 8'h01);
            if (!pulse && zrun_q + 8'h01 >= LOS_ZEROS) los_d = 1'b1;
            if (los_q && !wact_q && pulse) begin
                wact_d = 1'b1;
                wcnt_d = 8'h01;
                wones_d = 8'h01;
                wzrun_d = '0;
            end else if (wact_q) begin
                wcnt_d = wcnt_q + 8'h01;
                wones_d = wones_q + {7'h00, pulse};
                wzrun_d = pulse ? 7'h00 : wzrun_q + 7'h01;
                if (!pulse && wzrun_q + 7'h01 >= LOS_MAX_ZRUN) begin
                    wact_d = 1'b0;
                end else if (wcnt_q + 8'h01 == LOS_WINDOW) begin
                    wact_d = 1'b0;
                    if (wones_q + {7'h00, pulse} >= LOS_MIN_ONES) los_d = 1'b0;
                end
            end
        end
    end
    // flagged violation, seen as it reaches the output stage
    assign viol_ev = rise[3] && single_q && hist_q[3][0];

    // recovered clock: measured half period, reference presence, hold divider
    logic [HALF_W-1:0] hcnt_q, hcnt_d, half_q, half_d, div_q, div_d;
    logic [8:0] mto_q, mto_d;
    logic hold_q, hold_d, rclk_q, rclk_d, src, chg;
    logic rxp_q, rxp_d, rxn_q, rxn_d;
    always_comb begin
        hcnt_d = (rise[3] | fall[3]) ? '0 : hcnt_q + 1'b1;
        half_d = half_q;
        if ((rise[3] | fall[3]) && !los_q) half_d = hcnt_q;
        mto_d = rise[8] ? 9'h000 : (mto_q == MREF_TIMEOUT ? mto_q : mto_q + 9'h001);
        div_d = div_q + 1'b1;
        hold_d = hold_q;
        if (div_q >= half_q) begin
            div_d = '0;
            hold_d = ~hold_q; // keeps the last rate while the line is gone
        end
        if (!los_q) src = lvl[3];
        else if (mto_q != MREF_TIMEOUT) src = lvl[8];
        else src = hold_q;
        rclk_d = src;
        // data changes on the edge opposite the one it is valid on
        if (host_q && lvl[7]) chg = !rclk_q && src;
        else chg = rclk_q && !src;
        rxp_d = rxp_q;
        rxn_d = rxn_q;
        if (chg) begin
            if (single_q) begin
                rxp_d = bit_q[2] | bit_q[1];
                rxn_d = bit_q[0];
            end else begin
                rxp_d = bit_q[2];
                rxn_d = bit_q[1];
            end
        end
    end

    // AHB-Lite slave, zero wait states, registered read data
    logic [ST_W-1:0] status_q, status_d, mask_q, mask_d, ev;
    logic [7:0] waddr_q, waddr_d;
    logic wpend_q, wpend_d, irq_q, irq_d, was_single_q;
    logic [31:0] rdata_q, rdata_d;
    logic take;
    always_comb begin
        take = hsel_i && hready_i && htrans_i[1];
        wpend_d = take && hwrite_i;
        waddr_d = take ? haddr_i : waddr_q;
        rdata_d = 32'h0000_0000;
        if (take && !hwrite_i) begin
            unique case (haddr_i)
                ADDR_STATUS: rdata_d[ST_W-1:0] = status_q;
                ADDR_MASK: rdata_d[ST_W-1:0] = mask_q;
                ADDR_STATE: begin
                    rdata_d[SR_SINGLE] = single_q;
                    rdata_d[SR_LOS] = los_q;
                    rdata_d[SR_HOST] = host_q;
                    rdata_d[SR_HDB3] = hdb3;
                    rdata_d[SR_MREF] = (mto_q != MREF_TIMEOUT);
                    rdata_d[SR_HALF_LSB +: HALF_W] = half_q;
                end
                default: ;
            endcase
        end
        ev = '0;
        ev[ST_LOS_SET] = los_d && !los_q;
        ev[ST_LOS_CLR] = !los_d && los_q;
        ev[ST_VIOL] = viol_ev;
        ev[ST_FMT] = single_q != was_single_q;
        mask_d = mask_q;
        status_d = status_q;
        if (wpend_q && waddr_q == ADDR_MASK) mask_d = hwdata_i[ST_W-1:0];
        if (wpend_q && waddr_q == ADDR_STATUS) status_d = status_q & ~hwdata_i[ST_W-1:0];
        status_d = status_d | ev; // a new event beats the clear
        irq_d = |(status_d & mask_d);
    end

    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            mwin_q <= '0;
            medge_q <= '0;
            host_q <= 1'b0;
            mtog_q <= 1'b0;
            fmt_q <= '0;
            single_q <= 1'b0;
            esr_q <= '{default: SYM_ZERO};
            lastpol_q <= 1'b0;
            par_q <= 1'b0;
            txp_q <= 1'b0;
            txn_q <= 1'b0;
            hist_q <= '{default: 3'b000};
            rlast_q <= 1'b0;
            rseen_q <= 1'b0;
            bit_q <= 3'b000;
            zrun_q <= '0;
            wcnt_q <= '0;
            wones_q <= '0;
            wzrun_q <= '0;
            los_q <= 1'b0;
            wact_q <= 1'b0;
            hcnt_q <= '0;
            half_q <= '1;
            div_q <= '0;
            mto_q <= MREF_TIMEOUT;
            hold_q <= 1'b0;
            rclk_q <= 1'b0;
            rxp_q <= 1'b0;
            rxn_q <= 1'b0;
            status_q <= STATUS_RST;
            mask_q <= MASK_RST;
            waddr_q <= '0;
            wpend_q <= 1'b0;
            irq_q <= 1'b0;
            was_single_q <= 1'b0;
            rdata_q <= '0;
        end else begin
            mwin_q <= mwin_d;
            medge_q <= medge_d;
            host_q <= host_d;
            mtog_q <= mtog_d;
            fmt_q <= fmt_d;
            single_q <= single_d;
            esr_q <= esr_d;
            lastpol_q <= lastpol_d;
            par_q <= par_d;
            txp_q <= txp_d;
            txn_q <= txn_d;
            hist_q <= hist_d;
            rlast_q <= rlast_d;
            rseen_q <= rseen_d;
            bit_q <= bit_d;
            zrun_q <= zrun_d;
            wcnt_q <= wcnt_d;
            wones_q <= wones_d;
            wzrun_q <= wzrun_d;
            los_q <= los_d;
            wact_q <= wact_d;
            hcnt_q <= hcnt_d;
            half_q <= half_d;
            div_q <= div_d;
            mto_q <= mto_d;
            hold_q <= hold_d;
            rclk_q <= rclk_d;
            rxp_q <= rxp_d;
            rxn_q <= rxn_d;
            status_q <= status_d;
            mask_q <= mask_d;
            waddr_q <= waddr_d;
            wpend_q <= wpend_d;
            irq_q <= irq_d;
            was_single_q <= single_q;
            rdata_q <= rdata_d;
        end
    end

    assign tx_line_positive_o = txp_q;
    assign tx_line_negative_o = txn_q;
    assign rx_plus_rail_o = rxp_q;
    assign rx_minus_rail_o = rxn_q;
    assign rx_clock_o = rclk_q;
    assign signal_loss_indicator_o = los_q;
    assign hrdata_o = rdata_q;
    assign hreadyout_o = rst_n_i;
    assign hresp_o = 1'b0;
    assign irq_o = irq_q;
endmodule // e1_port

// ---- hw/pin_sync.sv ----
/*
 * Two-flop synchroniser with edge detection for a vector of pin inputs.
 * Assumes inputs are asynchronous to clk_i; only the second flop and the edge-detect flop after it are examined.
 */
`timescale 1ns/1ps
module pin_sync #(
    parameter int WIDTH = 1
) (
    // clock and reset
    input wire logic clk_i,
    input wire logic rst_n_i,
    // pins in, synchronised level and edges out
    input wire logic [WIDTH-1:0] pin_i,
    output logic [WIDTH-1:0] level_o,
    output logic [WIDTH-1:0] rise_o,
    output logic [WIDTH-1:0] fall_o
);
    logic [WIDTH-1:0] meta_q, meta_d;
    logic [WIDTH-1:0] sync_q, sync_d;
    logic [WIDTH-1:0] prev_q, prev_d;

    initial begin
        if (WIDTH < 1) $error("pin_sync: WIDTH must be at least 1");
    end

    always_comb begin
        meta_d = pin_i;
        sync_d = meta_q;
        prev_d = sync_q;
    end

    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            meta_q <= '0;
            sync_q <= '0;
            prev_q <= '0;
        end else begin
            meta_q <= meta_d;
            sync_q <= sync_d;
            prev_q <= prev_d;
        end
    end

    assign level_o = sync_q;
    assign rise_o = sync_q & ~prev_q;
    assign fall_o = ~sync_q & prev_q;
endmodule // pin_sync
